// ---- logic/sdram_addr_mux_burst_read.sv ----
// Synchronous DRAM address multiplexer and auto-precharge burst read sequencer.
`timescale 1ns/1ps
module sdram_addr_mux_burst_read
  import sdram_burst_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              busClk,
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic              reqArea3,
  input  wire logic              reqCacheFill,
  input  wire logic              dramWidthSel,
  input  wire logic [2:0]        rowColMapSel,
  input  wire logic              rasToCasSel,
  input  wire logic              prechargeWaitSel,
  input  wire logic [CL_W-1:0]   cs2CasLatency,
  input  wire logic [CL_W-1:0]   cs3CasLatency,
  input  wire logic [2:0]        areaTypeSel,
  output logic                   busy,
  output logic                   lineValid,
  output logic [LINE_W-1:0]      lineData,
  input  wire logic [31:0]       sdramData,
  output sdram_pins_t            sdramPins
);

  ////////////////////////////////////////////////////////////////////////////
  // Address multiplexer.

  function automatic logic [ADDR_W-1:0] muxAddr(input logic [ADDR_W-1:0] a, input logic wide,
                                                input logic [2:0] m, input logic row, input logic lh);
    logic [ADDR_W-1:0] o;
    int                shift;
    o     = a;
    shift = 8;
    if (wide && m == MAP_001) begin
      shift = 9;
    end else if (wide && m == MAP_010) begin
      shift = 10;
    end
    if (row) begin
      for (int k = 1; k <= 13; k++) begin
        o[k] = a[k + shift];
      end
      if (wide && m == MAP_111) begin
        o[10] = a[17];
        o[11] = a[18];
      end else if (!wide && m == MAP_111) begin
        o[9]  = a[16];
        o[10] = a[17];
      end
    end else begin
      if (wide) begin
        case (m)
          MAP_000, MAP_001, MAP_010: begin
            o[12] = lh;
            o[13] = a[21 + m];
          end
          MAP_011: begin
            o[10] = lh;
            o[11] = a[19];
          end
          MAP_111: begin
            o[10] = lh;
            o[11] = a[18];
          end
          default: begin
            o[12] = lh;
          end
        endcase
      end else begin
        case (m)
          MAP_000: begin
            o[11] = lh;
            o[12] = a[20];
          end
          MAP_011: begin
            o[9]  = lh;
            o[10] = a[18];
          end
          MAP_111: begin
            o[9]  = lh;
            o[10] = a[17];
          end
          default: begin
            o[11] = lh;
          end
        endcase
      end
    end
    return o;
  endfunction : muxAddr

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: request capture and line return.

  logic              pending_reg,   pending_next;
  logic              reqToggle_reg, reqToggle_next;
  read_req_t         reqHold_reg,   reqHold_next;
  logic              doneSeen_reg,  doneSeen_next;
  logic              lineValid_reg, lineValid_next;
  logic [LINE_W-1:0] lineData_reg,  lineData_next;
  logic              doneSync1_reg;
  logic              doneSync2_reg;
  logic              doneToggle_reg;
  logic [LINE_W-1:0] line_reg;
  logic              areaIsDram;

  // Requests to an area that is not set up as synchronous DRAM are never taken.
  assign areaIsDram = reqArea3 ? (areaTypeSel == AREA3_DRAM || areaTypeSel == BOTH_DRAM)
                               : (areaTypeSel == AREA2_DRAM || areaTypeSel == BOTH_DRAM);
  assign reqReady   = !pending_reg && areaIsDram;
  assign busy       = pending_reg;
  assign lineValid  = lineValid_reg;
  assign lineData   = lineData_reg;

  always_comb begin
    pending_next   = pending_reg;
    reqToggle_next = reqToggle_reg;
    reqHold_next   = reqHold_reg;
    doneSeen_next  = doneSeen_reg;
    lineValid_next = 1'h0;
    lineData_next  = lineData_reg;
    if (reqValid && reqReady) begin
      pending_next        = 1'h1;
      reqToggle_next      = !reqToggle_reg;
      reqHold_next.addr   = reqAddr;
      reqHold_next.area3  = reqArea3;
      reqHold_next.cacheFill = reqCacheFill;
      reqHold_next.wide   = dramWidthSel;
      reqHold_next.mapSel = rowColMapSel;
      reqHold_next.ras_to_cas_sel    = rasToCasSel;
      reqHold_next.precharge_wait_sel    = prechargeWaitSel;
      reqHold_next.casLat = reqArea3 ? cs3CasLatency : cs2CasLatency;
    end
    // The line is stable in the bus domain until the next request, so a toggle handshake suffices.
    if (doneSync2_reg != doneSeen_reg) begin
      doneSeen_next  = doneSync2_reg;
      pending_next   = 1'h0;
      lineValid_next = 1'h1;
      lineData_next  = line_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pending_reg   <= 1'h0;
      reqToggle_reg <= 1'h0;
      reqHold_reg   <= REQ_RESET;
      doneSeen_reg  <= 1'h0;
      lineValid_reg <= 1'h0;
      lineData_reg  <= '0;
      doneSync1_reg <= 1'h0;
      doneSync2_reg <= 1'h0;
    end else begin
      pending_reg   <= pending_next;
      reqToggle_reg <= reqToggle_next;
      reqHold_reg   <= reqHold_next;
      doneSeen_reg  <= doneSeen_next;
      lineValid_reg <= lineValid_next;
      lineData_reg  <= lineData_next;
      doneSync1_reg <= doneToggle_reg;
      doneSync2_reg <= doneSync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus domain: reset release, request synchroniser and falling-edge data capture.

  logic        busRstSync1_reg;
  logic        busRst_reg;
  logic        reqSync1_reg;
  logic        reqSync2_reg;
  logic [31:0] dataFall_reg;

  always_ff @(posedge busClk or posedge rst) begin
    if (rst) begin
      busRstSync1_reg <= 1'h1;
      busRst_reg      <= 1'h1;
    end else begin
      busRstSync1_reg <= 1'h0;
      busRst_reg      <= busRstSync1_reg;
    end
  end

  always_ff @(posedge busClk or posedge busRst_reg) begin
    if (busRst_reg) begin
      reqSync1_reg <= 1'h0;
      reqSync2_reg <= 1'h0;
    end else begin
      reqSync1_reg <= reqToggle_reg;
      reqSync2_reg <= reqSync1_reg;
    end
  end

  // Read data is taken at the fall inside each data state.
  always_ff @(negedge busClk or posedge busRst_reg) begin
    if (busRst_reg) begin
      dataFall_reg <= '0;
    end else begin
      dataFall_reg <= sdramData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus domain: burst read sequencer.

  typedef enum logic [2:0] {
    IDLE_ST, ACTIVATE_ST, RCD_NOP_ST, COLUMN_CMD_ST, LATENCY_NOP_ST, DATA_ST, PRECHARGE_WAIT_ST
  } burst_state_t;

  burst_state_t      state_reg,   state_next;
  read_req_t         cur_reg,     cur_next;
  logic              reqSeen_reg, reqSeen_next;
  logic [2:0]        cnt_reg,     cnt_next;
  logic [2:0]        beat_reg,    beat_next;
  logic              doneToggle_next;
  logic [LINE_W-1:0] line_next;
  sdram_pins_t       pins_reg,    pins_next;
  logic              newReq;
  logic [2:0]        lastBeat;
  logic [2:0]        latency;
  logic [2:0]        waitLen;
  logic [2:0]        wordIdx;
  logic [2:0]        nextIdx;

  assign newReq    = reqSync2_reg != reqSeen_reg;
  assign sdramPins = pins_reg;

  // Word position of a beat within the sixteen-byte line.
  function automatic logic [2:0] beatIdx(input read_req_t r, input logic [2:0] b);
    logic [2:0] idx;
    idx = '0;
    if (r.wide) begin
      idx = {1'h0, r.addr[3:2] + (r.cacheFill ? FILL_SKIP_32 : 2'h0) + b[1:0]};
    end else begin
      idx = r.addr[3:1] + (r.cacheFill ? FILL_SKIP_16 : 3'h0) + b;
    end
    return idx;
  endfunction : beatIdx

  always_comb begin
    lastBeat = cur_reg.wide ? LAST_BEAT_32 : LAST_BEAT_16;
    latency  = {1'h0, cur_reg.casLat} + 3'h1;
    // Precharge wait of zero cycles is possible at higher latency and skips the wait state.
    if (latency == 3'h1) begin
      waitLen = cur_reg.precharge_wait_sel ? 3'h2 : 3'h1;
    end else begin
      waitLen = cur_reg.precharge_wait_sel ? 3'h1 : 3'h0;
    end
    wordIdx = beatIdx(cur_reg, beat_reg);
  end

  always_comb begin
    state_next      = state_reg;
    cur_next        = cur_reg;
    reqSeen_next    = reqSeen_reg;
    cnt_next        = cnt_reg;
    beat_next       = beat_reg;
    doneToggle_next = doneToggle_reg;
    line_next       = line_reg;
    case (state_reg)
      IDLE_ST: begin
        if (newReq) begin
          cur_next     = reqHold_reg;
          reqSeen_next = reqSync2_reg;
          state_next   = ACTIVATE_ST;
        end
      end
      ACTIVATE_ST: begin
        state_next = cur_reg.ras_to_cas_sel ? RCD_NOP_ST : COLUMN_CMD_ST;
      end
      RCD_NOP_ST: begin
        state_next = COLUMN_CMD_ST;
      end
      COLUMN_CMD_ST: begin
        beat_next = '0;
        if (latency > 3'h1) begin
          cnt_next   = latency - 3'h2;
          state_next = LATENCY_NOP_ST;
        end else begin
          state_next = DATA_ST;
        end
      end
      LATENCY_NOP_ST: begin
        if (cnt_reg == 3'h0) begin
          state_next = DATA_ST;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      DATA_ST: begin
        if (cur_reg.wide) begin
          line_next[LINE_W - 1 - 32 * wordIdx[1:0] -: 32] = dataFall_reg;
        end else begin
          line_next[LINE_W - 1 - 16 * wordIdx -: 16] = dataFall_reg[15:0];
        end
        if (beat_reg == lastBeat) begin
          doneToggle_next = !doneToggle_reg;
          if (waitLen == 3'h0) begin
            state_next = IDLE_ST;
          end else begin
            cnt_next   = waitLen - 3'h1;
            state_next = PRECHARGE_WAIT_ST;
          end
        end else begin
          beat_next = beat_reg + 3'h1;
        end
      end
      PRECHARGE_WAIT_ST: begin
        // Only the bank of the finished area is precharging, so the other area may start now.
        if (newReq && reqHold_reg.area3 != cur_reg.area3) begin
          cur_next     = reqHold_reg;
          reqSeen_next = reqSync2_reg;
          state_next   = ACTIVATE_ST;
        end else if (cnt_reg == 3'h0) begin
          state_next = IDLE_ST;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      default: begin
        state_next = IDLE_ST;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus domain: pin drive, registered from the next state so pins line up with the state.

  always_comb begin
    pins_next           = PINS_RESET;
    nextIdx             = beatIdx(cur_next, beat_next);
    pins_next.addr      = cur_next.addr;
    if (state_next != IDLE_ST) begin
      pins_next.area2SelN = cur_next.area3;
      pins_next.area3SelN = !cur_next.area3;
      pins_next.laneMaskN = cur_next.wide ? MASK_READ_32 : MASK_READ_16;
    end
    case (state_next)
      ACTIVATE_ST: begin
        pins_next.rasN = 1'h0;
        pins_next.addr = muxAddr(cur_next.addr, cur_next.wide, cur_next.mapSel, 1'h1, CMD_BIT_READ_AUTOPRECHARGE_CMD);
      end
      COLUMN_CMD_ST: begin
        pins_next.casN = 1'h0;
        pins_next.addr = muxAddr(cur_next.addr, cur_next.wide, cur_next.mapSel, 1'h0, CMD_BIT_READ_AUTOPRECHARGE_CMD);
      end
      DATA_ST: begin
        pins_next.busCycleStartN = 1'h0;
        if (cur_next.wide) begin
          pins_next.addr[3:2] = nextIdx[1:0];
        end else begin
          pins_next.addr[3:1] = nextIdx;
        end
      end
      PRECHARGE_WAIT_ST: begin
        pins_next.laneMaskN = MASK_IDLE;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge busClk or posedge busRst_reg) begin
    if (busRst_reg) begin
      state_reg      <= IDLE_ST;
      cur_reg        <= REQ_RESET;
      reqSeen_reg    <= 1'h0;
      cnt_reg        <= '0;
      beat_reg       <= '0;
      doneToggle_reg <= 1'h0;
      line_reg       <= '0;
      pins_reg       <= PINS_RESET;
    end else begin
      state_reg      <= state_next;
      cur_reg        <= cur_next;
      reqSeen_reg    <= reqSeen_next;
      cnt_reg        <= cnt_next;
      beat_reg       <= beat_next;
      doneToggle_reg <= doneToggle_next;
      line_reg       <= line_next;
      pins_reg       <= pins_next;
    end
  end

endmodule : sdram_addr_mux_burst_read

// ---- logic/sdram_burst_pkg.sv ----
// Shared constants, types and carriers of the synchronous DRAM burst read block.
package sdram_burst_pkg;

  localparam int ADDR_W        = 27;
  localparam int LINE_W        = 128;
  localparam int CL_W          = 2;

  // Row and column multiplex codes.
  localparam logic [2:0] MAP_000 = 3'h0;
  localparam logic [2:0] MAP_001 = 3'h1;
  localparam logic [2:0] MAP_010 = 3'h2;
  localparam logic [2:0] MAP_011 = 3'h3;
  localparam logic [2:0] MAP_111 = 3'h7;

  // Area type codes that make an area synchronous DRAM.
  localparam logic [2:0] AREA3_DRAM    = 3'h1;
  localparam logic [2:0] AREA2_DRAM    = 3'h4;
  localparam logic [2:0] BOTH_DRAM     = 3'h5;

  // Burst geometry.
  localparam logic [2:0] LAST_BEAT_32  = 3'h3;
  localparam logic [2:0] LAST_BEAT_16  = 3'h7;
  localparam logic [1:0] FILL_SKIP_32  = 2'h1;
  localparam logic [2:0] FILL_SKIP_16  = 3'h2;

  // Level of the command bit in the column phase of a read with auto-precharge.
  localparam logic       CMD_BIT_READ_AUTOPRECHARGE_CMD = 1'h1;

  // Lane masks, active low, bit 3 covers byte 4n.
  localparam logic [3:0] MASK_READ_32  = 4'h0;
  localparam logic [3:0] MASK_READ_16  = 4'hC;
  localparam logic [3:0] MASK_IDLE     = 4'hF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              area3;
    logic              cacheFill;
    logic              wide;
    logic [2:0]        mapSel;
    logic              ras_to_cas_sel;
    logic              precharge_wait_sel;
    logic [CL_W-1:0]   casLat;
  } read_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rasN;
    logic              casN;
    logic              weN;
    logic              area2SelN;
    logic              area3SelN;
    logic [3:0]        laneMaskN;
    logic              busCycleStartN;
    logic              cke;
  } sdram_pins_t;

  localparam read_req_t   REQ_RESET  = '0;
  localparam sdram_pins_t PINS_RESET = '{addr: '0, rasN: 1'h1, casN: 1'h1, weN: 1'h1, area2SelN: 1'h1,
                                         area3SelN: 1'h1, laneMaskN: 4'hF, busCycleStartN: 1'h1, cke: 1'h1};

endpackage : sdram_burst_pkg

// ---- verification/sdram_addr_mux_burst_read_chk.sv ----
// Concurrent checks on the pins and handshake of the SDRAM burst read block.
`timescale 1ns/1ps
module sdram_addr_mux_burst_read_chk
  import sdram_burst_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            rst,
  input wire logic            busClk,
  input wire logic            reqValid,
  input wire logic            reqReady,
  input wire logic            busy,
  input wire logic            lineValid,
  input wire logic            dramWidthSel,
  input wire logic            rasToCasSel,
  input wire logic            prechargeWaitSel,
  input wire logic [CL_W-1:0] cs2CasLatency,
  input wire logic [CL_W-1:0] cs3CasLatency,
  input wire sdram_pins_t     sdramPins
);
  logic [3:0] gap;
  logic [3:0] beats;
  logic [3:0] tap;
  logic [3:0] waitLen;
  logic [1:0] cl;
  logic [1:0] clHold;
  logic       wideHold;
  logic       trpHold;
  logic       selN;
  logic       bsN;
  // Settings may change for the next request while the precharge wait still runs.
  // One select stays low through the precharge wait, so the settings of a burst are latched at its activate.
  assign selN = sdramPins.area2SelN & sdramPins.area3SelN;
  assign bsN = sdramPins.busCycleStartN;
  assign cl = clHold;
  assign waitLen = (cl == 2'h0) ? (trpHold ? 4'h2 : 4'h1) : (trpHold ? 4'h1 : 4'h0);
  always_ff @(posedge busClk or posedge rst) begin
    if (rst) begin
      gap <= 4'h0;
      beats <= 4'h0;
      tap <= 4'h0;
      clHold <= 2'h0;
      wideHold <= 1'h0;
      trpHold <= 1'h0;
    end else begin
      gap <= !sdramPins.casN ? 4'h0 : (gap == 4'hF ? gap : gap + 4'h1);
      beats <= !sdramPins.rasN ? 4'h0 : (!bsN ? beats + 4'h1 : beats);
      tap <= !sdramPins.rasN ? 4'h0 : ((!selN && bsN && beats != 4'h0) ? tap + 4'h1 : tap);
      if (!sdramPins.rasN) begin
        clHold <= sdramPins.area3SelN ? cs2CasLatency : cs3CasLatency;
        wideHold <= dramWidthSel;
        trpHold <= prechargeWaitSel;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence nop_s;
    sdramPins.rasN && sdramPins.casN && sdramPins.weN;
  endsequence
  sequence col_s;
    !sdramPins.casN && sdramPins.rasN && sdramPins.weN;
  endsequence
  act_col_a: assert property (@(posedge busClk) disable iff (rst)
    !sdramPins.rasN && !rasToCasSel |=> col_s) else $error("column command late");
  act_nop_col_a: assert property (@(posedge busClk) disable iff (rst)
    !sdramPins.rasN && rasToCasSel |=> nop_s ##1 col_s) else $error("missing gap before column");
  cas_latency_a: assert property (@(posedge busClk) disable iff (rst)
    !bsN && beats == 4'h0 |-> gap == {2'h0, cl}) else $error("first data at wrong latency");
  beat_count_a: assert property (@(posedge busClk) disable iff (rst)
    $rose(bsN) |-> beats == (wideHold ? 4'h4 : 4'h8)) else $error("wrong count of data states");
  burst_addr_a: assert property (@(posedge busClk) disable iff (rst) !bsN && $past(!bsN) |->
    (dramWidthSel ? sdramPins.addr[3:2] == $past(sdramPins.addr[3:2]) + 2'h1
                  : sdramPins.addr[3:1] == $past(sdramPins.addr[3:1]) + 3'h1)
    && sdramPins.addr[26:4] == $past(sdramPins.addr[26:4])) else $error("burst address step wrong");
  wait_len_a: assert property (@(posedge busClk) disable iff (rst)
    $rose(selN) |-> tap == waitLen) else $error("precharge wait length wrong");
  wait_nop_a: assert property (@(posedge busClk) disable iff (rst)
    !selN && bsN && sdramPins.rasN && beats != 4'h0 |-> nop_s) else $error("command during precharge wait");
  lane_mask_a: assert property (@(posedge busClk) disable iff (rst)
    !bsN |-> sdramPins.laneMaskN == (dramWidthSel ? MASK_READ_32 : MASK_READ_16)) else $error("lane masks wrong");
  accept_busy_a: assert property (@(posedge core_clk) disable iff (rst)
    reqValid && reqReady |=> busy && !reqReady) else $error("accepted request not held busy");
  line_done_a: assert property (@(posedge core_clk) disable iff (rst)
    lineValid |-> !busy && $past(busy)) else $error("line delivered outside a request");
endmodule : sdram_addr_mux_burst_read_chk

bind sdram_addr_mux_burst_read sdram_addr_mux_burst_read_chk chk_u (.core_clk(core_clk), .rst(rst),
  .busClk(busClk), .reqValid(reqValid), .reqReady(reqReady), .busy(busy), .lineValid(lineValid),
  .dramWidthSel(dramWidthSel), .rasToCasSel(rasToCasSel), .prechargeWaitSel(prechargeWaitSel),
  .cs2CasLatency(cs2CasLatency), .cs3CasLatency(cs3CasLatency), .sdramPins(sdramPins));

// ---- verification/sdram_addr_mux_burst_read_tb.sv ----
// Self-checking bench of the SDRAM burst read block.
`timescale 1ns/1ps
module sdram_addr_mux_burst_read_tb
  import sdram_burst_pkg::*;
;
  logic core_clk, rst, busClk, reqValid, reqReady, reqArea3, reqCacheFill, dramWidthSel;
  logic rasToCasSel, prechargeWaitSel, busy, lineValid, firstSeen;
  logic [ADDR_W-1:0] reqAddr, rowSeen, colSeen;
  logic [2:0]        rowColMapSel, areaTypeSel, firstIdx, startIdx;
  logic [1:0]        selSeen;
  logic [CL_W-1:0]   cs2CasLatency, cs3CasLatency;
  logic [LINE_W-1:0] lineData;
  logic [31:0]       sdramData, seed;
  sdram_pins_t       sdramPins;
  int                nFail, totalChecks, n;
  logic [2:0]        mapList [5] = '{MAP_000, MAP_001, MAP_010, MAP_011, MAP_111};

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    busClk = 1'b0;
    #3;
    forever #40 busClk = ~busClk;
  end

  sdram_addr_mux_burst_read dut_u (.core_clk(core_clk), .rst(rst), .busClk(busClk), .reqValid(reqValid),
    .reqReady(reqReady), .reqAddr(reqAddr), .reqArea3(reqArea3), .reqCacheFill(reqCacheFill),
    .dramWidthSel(dramWidthSel), .rowColMapSel(rowColMapSel), .rasToCasSel(rasToCasSel),
    .prechargeWaitSel(prechargeWaitSel), .cs2CasLatency(cs2CasLatency), .cs3CasLatency(cs3CasLatency),
    .areaTypeSel(areaTypeSel), .busy(busy), .lineValid(lineValid), .lineData(lineData),
    .sdramData(sdramData), .sdramPins(sdramPins));
  sdram_model model_u (.busClk(busClk), .sdramPins(sdramPins), .sdramData(sdramData));

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pat(input logic [26:0] a);
    return {a[15:0] ^ 16'hA5C3, a[15:0]};
  endfunction : pat
  function automatic logic [127:0] expLine(input logic [26:0] a, input logic w);
    logic [127:0] l;
    l = '0;
    for (int k = 0; k < 8; k++) begin
      if (w && k < 4) l[127-32*k -: 32] = pat({a[26:4], 2'(k), a[1:0]});
      else if (!w) l[127-16*k -: 16] = 16'(pat({a[26:4], 3'(k), a[0]}));
    end
    return l;
  endfunction : expLine
  function automatic logic [26:0] expMux(input logic [26:0] a, input logic w, input logic [2:0] m, input logic r);
    logic [13:1] p;
    p = r ? a[21:9] : a[13:1];
    if (w && m < 3'h3) p = r ? 13'(a >> (9 + m)) : {a[21 + m], CMD_BIT_READ_AUTOPRECHARGE_CMD, a[11:1]};
    else if (w && m == 3'h3 && !r) p[11:10] = {a[19], CMD_BIT_READ_AUTOPRECHARGE_CMD};
    else if (w && m == 3'h7) p[11:10] = r ? {a[18], a[17]} : {a[18], CMD_BIT_READ_AUTOPRECHARGE_CMD};
    else if (!w && m == 3'h0 && !r) p[12:11] = {a[20], CMD_BIT_READ_AUTOPRECHARGE_CMD};
    else if (!w && !r) p[10:9] = {m[2] ? a[17] : a[18], CMD_BIT_READ_AUTOPRECHARGE_CMD};
    else if (!w && m == 3'h7) p[10:9] = {a[17], a[16]};
    return {a[26:14], p, a[0]};
  endfunction : expMux
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xorshift
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic testDone();
    if (nFail == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : testDone

  // Pins are sampled mid-cycle, well clear of the registered edge.
  always @(negedge busClk) begin
    if (!sdramPins.rasN) begin
      rowSeen = sdramPins.addr;
      selSeen = {sdramPins.area3SelN, sdramPins.area2SelN};
      firstSeen = 1'b0;
    end
    if (!sdramPins.casN) colSeen = sdramPins.addr;
    if (!sdramPins.busCycleStartN && !firstSeen) begin
      firstIdx = dramWidthSel ? {1'b0, sdramPins.addr[3:2]} : sdramPins.addr[3:1];
      firstSeen = 1'b1;
    end
  end

  initial begin
    #400000;
    nFail++;
    testDone();
  end

  initial begin
    {rst, reqValid, reqArea3, reqCacheFill, dramWidthSel, rasToCasSel, prechargeWaitSel} = 7'h40;
    {reqAddr, rowColMapSel, cs2CasLatency, cs3CasLatency, areaTypeSel, firstSeen} = '0;
    seed = 32'h4343;
    nFail = 0;
    totalChecks = 0;
    // The slow bus domain needs several of its own edges to leave reset.
    repeat (4) @(posedge busClk);
    @(negedge core_clk) rst = 1'b0;
    repeat (3) @(posedge busClk);
    for (int k = 0; k < 4; k++) begin
      @(negedge core_clk);
      areaTypeSel = k[1] ? AREA2_DRAM : AREA3_DRAM;
      reqArea3 = k[0];
      reqValid = !(k[1] ^ k[0]);
      repeat (3) @(negedge core_clk);
      check(reqReady, k[1] ^ k[0]);
      check(busy, 1'b0);
      reqValid = 1'b0;
    end
    for (int i = 0; i < 44; i++) begin
      @(negedge core_clk);
      seed = xorshift(seed);
      reqAddr = i < 4 ? {27{i[0]}} : seed[26:0];
      seed = xorshift(seed);
      {dramWidthSel, reqArea3, cs3CasLatency} = seed[3:0];
      {prechargeWaitSel, rasToCasSel, cs2CasLatency} = i[3:0];
      reqCacheFill = i[0] ^ seed[7];
      rowColMapSel = mapList[(i + seed[9:8]) % 5];
      if (!dramWidthSel && rowColMapSel inside {MAP_001, MAP_010}) rowColMapSel = MAP_011;
      areaTypeSel = seed[10] ? BOTH_DRAM : (reqArea3 ? AREA3_DRAM : AREA2_DRAM);
      reqValid = 1'b1;
      n = 0;
      while (reqReady !== 1'b1 && n < 50) begin
        @(negedge core_clk);
        n++;
      end
      @(negedge core_clk) reqValid = 1'b0;
      while (lineValid !== 1'b1 && n < 5000) begin
        @(negedge core_clk);
        n++;
      end
      if (n >= 5000) nFail++;
      startIdx = dramWidthSel ? {1'b0, reqAddr[3:2] + (reqCacheFill ? FILL_SKIP_32 : 2'h0)}
                              : reqAddr[3:1] + (reqCacheFill ? FILL_SKIP_16 : 3'h0);
      check(lineData, expLine(reqAddr, dramWidthSel));
      check(rowSeen, expMux(reqAddr, dramWidthSel, rowColMapSel, 1'b1));
      check(colSeen, expMux(reqAddr, dramWidthSel, rowColMapSel, 1'b0));
      check(firstIdx, startIdx);
      check(selSeen, {!reqArea3, reqArea3});
    end
    testDone();
  end
endmodule : sdram_addr_mux_burst_read_tb

// ---- verification/sdram_model.sv ----
// Behavioural SDRAM pair that answers each data state from the address on the pins.
`timescale 1ns/1ps
module sdram_model
  import sdram_burst_pkg::*;
(
  input  wire logic        busClk,
  input  wire sdram_pins_t sdramPins,
  output logic [31:0]      sdramData
);
  initial sdramData = 32'h0;
  // A released bus flips every cycle so that stale data can never look right.
  always @(posedge busClk) begin
    #1;
    if (!sdramPins.busCycleStartN && !(sdramPins.area2SelN && sdramPins.area3SelN)) begin
      sdramData <= {sdramPins.addr[15:0] ^ 16'hA5C3, sdramPins.addr[15:0]};
    end else begin
      sdramData <= ~sdramData;
    end
  end
endmodule : sdram_model
